// *** rtl/pfh_ctrl.sv ***
// primary side fault supervisor and handshake controller
// Overview of operation
// - supply below low level inhibits switching until full regulation returns
// - limit level latched at power-up from supply capacitor size
// - supply overcurrent latches off or retries per option code
// - hysteretic thermal: stop above trip, resume after hysteresis cooldown
// - latch-off cleared only by supply clear or line-low
// - limit rises as off gap shortens, floor at 30 percent
// - limit jitters between 100 and 95 percent at jitter rate
// - retry holds switching off for the retry off window
// - requests above 110 kHz for over 82 ms enter retry
// - request silence beyond the limit enters retry
// - AC line reset cancels retry immediately
// - two fast-peak cycles skip about 25 microseconds of switching
// - before first switch, line must be above brown-in and below overvoltage
// - brown-out persisting past line-low delay enters retry; resume above brown-in
// - line overvoltage enters retry until line back in range
// - sense switch continuous below 50 us gaps, sampled otherwise
// - grounded line pin disables line protection
// - start-up switches alone; no feedback in retry on window enters retry
// - after a stop, return to start-up and look for handshake
// - after recovery wait 82 ms listening; two requests at most 60 us apart hand over
`timescale 1ns/1ps
module pfh_ctrl
  import pfh_pkg::*;
#(
  parameter int RETRY_ON  = RETRY_ON_CYC,
  parameter int RETRY_OFF = RETRY_OFF_CYC,
  parameter int SILENCE   = SILENCE_CYC,
  parameter int LINE_LOW  = LINE_LOW_CYC,
  parameter int JIT_HALF  = JITTER_HALF_CYC
)(
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       supply_low,
  input  wire logic       supply_regulated,
  input  wire logic       supply_clear,
  input  wire logic       big_cap_detect,
  input  wire logic       bypass_fault,
  input  wire logic       latch_option,
  input  wire logic       thermal_trip,
  input  wire logic       thermal_cool,
  input  wire logic       thermal_latch_option,
  input  wire logic       line_above_brown_in,
  input  wire logic       line_below_brown_out,
  input  wire logic       line_over,
  input  wire logic       line_pin_grounded,
  input  wire logic       ac_reset,
  input  wire logic       sec_request,
  input  wire logic       peak_fast,
  input  wire logic       sw_off,
  output logic            switch_enable,
  output logic            auto_pulse,
  output logic            limit_high,
  output logic      [6:0] limit_pct,
  output logic            sense_switch_on,
  output logic            latched_off,
  output logic            in_retry,
  output logic            sec_in_control
);
  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  localparam int NIN = 17;
  logic [NIN-1:0] raw;
  logic [NIN-1:0] s1;
  logic [NIN-1:0] s2;
  assign raw = {supply_low, supply_regulated, supply_clear, big_cap_detect, bypass_fault,
                latch_option, thermal_trip, thermal_cool, thermal_latch_option,
                line_above_brown_in, line_below_brown_out, line_over, line_pin_grounded,
                ac_reset, sec_request, peak_fast, sw_off};
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      s1 <= '0;
      s2 <= '0;
    end
    else
    begin
      s1 <= raw;
      s2 <= s1;
    end
  end
  logic y_low, y_reg, y_clr, y_cap, y_bf, y_lopt, y_tt, y_tc, y_topt;
  logic y_bi, y_bo, y_ov, y_gnd, y_acr, y_req, y_pk, y_off;
  assign {y_low, y_reg, y_clr, y_cap, y_bf, y_lopt, y_tt, y_tc, y_topt,
          y_bi, y_bo, y_ov, y_gnd, y_acr, y_req, y_pk, y_off} = s2;

  // ---------------------------------------------------------------
  // state record
  // ---------------------------------------------------------------
  typedef struct packed {
    pfh_state_e       st;
    logic             powered;
    logic             uv_block;
    logic             hot;
    logic             req_d;
    logic             off_d;
    logic             pk_d;
    logic             pk_prev;
    logic             got_one;
    logic             limit_high;
    logic             sw_en;
    logic             apulse;
    logic             sense_on;
    logic [CNT_W-1:0] win;
    logic [CNT_W-1:0] silence;
    logic [CNT_W-1:0] line_low;
    logic [CNT_W-1:0] req_gap;
    logic [CNT_W-1:0] ovl;
    logic [CNT_W-1:0] skip;
    logic [CNT_W-1:0] sw_gap;
    logic [CNT_W-1:0] auto_cnt;
  } pfh_ctrl_s;

  pfh_ctrl_s q;
  pfh_ctrl_s next_q;

  function automatic logic [CNT_W-1:0] inc_sat(input logic [CNT_W-1:0] v);
    return (v == {CNT_W{1'b1}}) ? v : v + 1'b1;
  endfunction

  logic req_pulse;
  logic off_pulse;
  logic line_ok;
  logic line_prot;
  logic latch_cause;
  logic retry_cause;
  assign req_pulse = y_req & ~q.req_d;
  assign off_pulse = y_off & ~q.off_d;
  assign line_prot = ~y_gnd;
  assign line_ok   = ~line_prot | (y_bi & ~y_ov);

  always_comb
  begin
    next_q = q;
    next_q.req_d = y_req;
    next_q.off_d = y_off;
    next_q.apulse = 1'b0;
    latch_cause = 1'b0;
    retry_cause = 1'b0;

    // limit selection caught once after the supply first charges
    if (!q.powered && y_reg)
    begin
      next_q.powered = 1'b1;
      next_q.limit_high = y_cap;
    end
    if (y_low)
      next_q.uv_block = 1'b1;
    else if (y_reg)
      next_q.uv_block = 1'b0;
    if (!y_topt)
    begin
      if (y_tt)
        next_q.hot = 1'b1;
      else if (y_tc)
        next_q.hot = 1'b0;
    end
    else
      next_q.hot = 1'b0;

    // counters
    next_q.silence = req_pulse ? '0 : inc_sat(q.silence);
    next_q.req_gap = req_pulse ? '0 : inc_sat(q.req_gap);
    next_q.sw_gap  = off_pulse ? '0 : inc_sat(q.sw_gap);
    if (line_prot && y_bo && !y_bi)
      next_q.line_low = inc_sat(q.line_low);
    else
      next_q.line_low = '0;
    // sustained overload: every request gap shorter than the 110 kHz period
    if (req_pulse)
      next_q.ovl = (q.req_gap < CNT_W'(OVERLOAD_GAP_CYC)) ? inc_sat(q.ovl) : '0;
    else if (q.req_gap >= CNT_W'(OVERLOAD_GAP_CYC))
      next_q.ovl = '0;
    else
      next_q.ovl = inc_sat(q.ovl);
    next_q.sense_on = (q.sw_gap < CNT_W'(SAMPLE_GAP_CYC)) || (q.sw_gap[7:0] == 8'h00);

    // two back-to-back fast peaks open a skip window
    if (off_pulse)
    begin
      next_q.pk_prev = q.pk_d;
      next_q.pk_d = 1'b0;
      if (q.pk_d && q.pk_prev)
        next_q.skip = CNT_W'(SOA_SKIP_CYC);
    end
    else if (y_pk)
      next_q.pk_d = 1'b1;
    if (q.skip != '0)
      next_q.skip = q.skip - 1'b1;

    // fault causes
    if (y_bf && y_lopt)
      latch_cause = 1'b1;
    if (y_tt && y_topt)
      latch_cause = 1'b1;
    if (y_bf && !y_lopt)
      retry_cause = 1'b1;
    if (q.ovl >= CNT_W'(RETRY_ON))
      retry_cause = 1'b1;
    if (q.st == PFH_SLAVE && q.silence >= CNT_W'(SILENCE))
      retry_cause = 1'b1;
    if (q.line_low >= CNT_W'(LINE_LOW))
      retry_cause = 1'b1;
    if (line_prot && y_ov)
      retry_cause = 1'b1;

    next_q.win = inc_sat(q.win);
    unique case (q.st)
      PFH_IDLE:
      begin
        if (q.powered && line_ok)
        begin
          next_q.st = PFH_LISTEN;
          next_q.win = '0;
          next_q.got_one = 1'b0;
        end
      end
      PFH_LISTEN:
      begin
        if (req_pulse)
        begin
          if (q.got_one && q.req_gap <= CNT_W'(2 * LISTEN_GAP_CYC))
            next_q.st = PFH_SLAVE;
          next_q.got_one = 1'b1;
        end
        else if (q.win >= CNT_W'(RETRY_ON))
        begin
          next_q.st = PFH_PRIMARY;
          next_q.win = '0;
        end
      end
      PFH_PRIMARY:
      begin
        if (req_pulse)
          next_q.st = PFH_SLAVE;
        else if (q.win >= CNT_W'(RETRY_ON))
          retry_cause = 1'b1;
      end
      PFH_SLAVE:
      begin
      end
      PFH_RETRY:
      begin
        if (q.win >= CNT_W'(RETRY_OFF) && line_ok)
        begin
          next_q.st = PFH_LISTEN;
          next_q.win = '0;
          next_q.got_one = 1'b0;
        end
      end
      PFH_LATCH:
      begin
        if (y_clr || (line_prot && !y_bi && y_bo))
          next_q.st = PFH_IDLE;
      end
      default:
        next_q.st = PFH_IDLE;
    endcase

    // priority: latch over retry over switching
    if (latch_cause && q.st != PFH_LATCH)
      next_q.st = PFH_LATCH;
    else if (retry_cause && q.st != PFH_LATCH && q.st != PFH_RETRY)
    begin
      next_q.st = PFH_RETRY;
      next_q.win = '0;
    end
    if (y_acr && q.st == PFH_RETRY && !latch_cause)
    begin
      next_q.st = PFH_IDLE;
      next_q.win = '0;
    end

    // own timing pulses while in primary control, about 1 ms apart
    if (q.st == PFH_PRIMARY)
    begin
      if (q.auto_cnt >= CNT_W'(CLK_MHZ * 1000 - 1))
      begin
        next_q.auto_cnt = '0;
        next_q.apulse = 1'b1;
      end
      else
        next_q.auto_cnt = q.auto_cnt + 1'b1;
    end
    else
      next_q.auto_cnt = '0;

    next_q.sw_en = (next_q.st == PFH_PRIMARY || next_q.st == PFH_SLAVE)
                   && !next_q.uv_block && !next_q.hot && next_q.skip == '0;
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      q <= '0;
    else
      q <= next_q;
  end

  pfh_limit #(
    .JIT_HALF (JIT_HALF)
  ) u_limit (
    .clock        (clock),
    .rst          (rst),
    .sw_off_pulse (off_pulse),
    .limit_pct    (limit_pct)
  );

  assign switch_enable   = q.sw_en;
  assign auto_pulse      = q.apulse;
  assign limit_high      = q.limit_high;
  assign sense_switch_on = q.sense_on;
  assign latched_off     = (q.st == PFH_LATCH);
  assign in_retry        = (q.st == PFH_RETRY);
  assign sec_in_control  = (q.st == PFH_SLAVE);

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_uv_inhibit: assert property (@(posedge clock) disable iff (rst)
    q.uv_block |-> !switch_enable)
    else $error("switching while supply low");
  a_latch_wins: assert property (@(posedge clock) disable iff (rst)
    latched_off |-> !switch_enable && !in_retry)
    else $error("latch-off did not dominate");
  a_retry_off: assert property (@(posedge clock) disable iff (rst)
    $rose(in_retry) |-> !switch_enable [*8])
    else $error("switched during retry off window");
  a_hot_stop: assert property (@(posedge clock) disable iff (rst)
    q.hot |-> !switch_enable)
    else $error("switching while hot");
  a_skip_hold: assert property (@(posedge clock) disable iff (rst)
    q.skip != '0 |-> !switch_enable)
    else $error("switching during skip");
  a_sense_cont: assert property (@(posedge clock) disable iff (rst)
    q.sw_gap < CNT_W'(SAMPLE_GAP_CYC) |=> sense_switch_on)
    else $error("sense switch off at short gap");
  a_ac_cancel: assert property (@(posedge clock) disable iff (rst)
    in_retry && y_acr && !latch_cause |=> !in_retry)
    else $error("retry survived line reset");
  a_ov_retry: assert property (@(posedge clock) disable iff (rst)
    line_prot && y_ov && !latched_off && !latch_cause && !y_acr |=> in_retry)
    else $error("line overvoltage missed retry");
endmodule // pfh_ctrl

// *** rtl/pfh_limit.sv ***
// per-cycle current limit shaping with jitter
`timescale 1ns/1ps
module pfh_limit
  import pfh_pkg::*;
#(
  parameter int JIT_HALF = JITTER_HALF_CYC
)(
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       sw_off_pulse,
  output logic      [6:0] limit_pct
);
  typedef struct packed {
    logic [CNT_W-1:0] gap;
    logic [CNT_W-1:0] jit;
    logic             jit_low;
    logic [6:0]       pct;
  } pfh_lim_s;

  pfh_lim_s q;
  pfh_lim_s next_q;

  always_comb
  begin
    logic [6:0] base;
    base = PCT_FULL;
    next_q = q;
    // limit decays one percent per microsecond of idle gap
    if (sw_off_pulse)
      next_q.gap = '0;
    else if (q.gap != {CNT_W{1'b1}})
      next_q.gap = q.gap + 1'b1;
    if (q.gap / CLK_MHZ >= CNT_W'(PCT_FULL - PCT_FLOOR))
      base = PCT_FLOOR;
    else
      base = PCT_FULL - 7'(q.gap / CLK_MHZ);
    if (q.jit >= CNT_W'(JIT_HALF - 1))
    begin
      next_q.jit = '0;
      next_q.jit_low = ~q.jit_low;
    end
    else
      next_q.jit = q.jit + 1'b1;
    // jitter only trims when base is above PCT_JIT_LOW so the trim never goes below 95 percent
    if (q.jit_low && base > PCT_JIT_LOW)
      next_q.pct = base - 7'(((base - PCT_JIT_LOW) * 7'h05) / 7'h05 > 7'h05 ? 7'h05 : base - PCT_JIT_LOW);
    else
      next_q.pct = base;
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      q <= '{gap: '0, jit: '0, jit_low: 1'b0, pct: PCT_FULL};
    else
      q <= next_q;
  end

  assign limit_pct = q.pct;

  a_limit_floor: assert property (@(posedge clock) disable iff (rst)
    limit_pct >= PCT_FLOOR && limit_pct <= PCT_FULL)
    else $error("current limit left its range");
endmodule // pfh_limit

// *** rtl/pfh_pkg.sv ***
// constants and types for the primary fault handshake controller
package pfh_pkg;
  localparam int  CLK_MHZ            = 100;
  // supervisory times in their own units
  localparam int  RETRY_ON_MS        = 82;
  localparam int  RETRY_OFF_MS       = 1000;
  localparam int  SILENCE_MS         = 150;
  localparam int  LINE_LOW_MS        = 30;
  localparam int  SOA_SKIP_US        = 25;
  localparam int  LISTEN_GAP_US      = 30;
  localparam int  SAMPLE_GAP_US      = 50;
  localparam int  OVERLOAD_KHZ       = 110;
  localparam int  JITTER_KHZ         = 1;
  localparam int  SOA_WIN_NS         = 500;
  // derived cycle counts
  localparam int  RETRY_ON_CYC       = RETRY_ON_MS * 1000 * CLK_MHZ;
  localparam int  RETRY_OFF_CYC      = RETRY_OFF_MS * 1000 * CLK_MHZ;
  localparam int  SILENCE_CYC        = SILENCE_MS * 1000 * CLK_MHZ;
  localparam int  LINE_LOW_CYC       = LINE_LOW_MS * 1000 * CLK_MHZ;
  localparam int  SOA_SKIP_CYC       = SOA_SKIP_US * CLK_MHZ;
  localparam int  LISTEN_GAP_CYC     = LISTEN_GAP_US * CLK_MHZ;
  localparam int  SAMPLE_GAP_CYC     = SAMPLE_GAP_US * CLK_MHZ;
  localparam int  OVERLOAD_GAP_CYC   = (CLK_MHZ * 1000) / OVERLOAD_KHZ;
  localparam int  JITTER_HALF_CYC    = (CLK_MHZ * 1000) / (2 * JITTER_KHZ);
  localparam int  SOA_WIN_CYC        = (SOA_WIN_NS * CLK_MHZ) / 1000;
  // limit scale in percent
  localparam logic [6:0] PCT_FULL    = 7'h64;
  localparam logic [6:0] PCT_FLOOR   = 7'h1E;
  localparam logic [6:0] PCT_JIT_LOW = 7'h5F;
  localparam logic [6:0] PCT_STEP    = 7'h01;
  localparam int  CNT_W              = 32;

  typedef enum logic [2:0] {
    PFH_IDLE    = 3'b000,
    PFH_LISTEN  = 3'b001,
    PFH_PRIMARY = 3'b010,
    PFH_SLAVE   = 3'b011,
    PFH_RETRY   = 3'b100,
    PFH_LATCH   = 3'b101
  } pfh_state_e;
endpackage

// *** verification/pfh_sec_model.sv ***
// secondary-side request source facing the primary fault handshake controller
`timescale 1ns/1ps
module pfh_sec_model
#(
  parameter int PULSE = 4
)(
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        enable,
  input  wire logic [15:0] gap,
  input  wire logic        sw_off,
  output logic             sec_request,
  output logic             rehandshake
);
  int   cnt;
  int   missed;
  logic off_d;

  // requests are evenly spaced, so two of them form the handshake pair
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      cnt         <= 0;
      missed      <= 0;
      off_d       <= 1'b0;
      sec_request <= 1'b0;
      rehandshake <= 1'b0;
    end
    else
    begin
      off_d       <= sw_off;
      sec_request <= enable && (cnt < PULSE);
      cnt         <= (!enable || cnt >= int'(gap) - 1) ? 0 : cnt + 1;
      if (sw_off && !off_d)
        missed <= 0;
      else if (enable && cnt == 0)
        missed <= missed + 1;
      rehandshake <= (missed >= 8);
    end
  end
endmodule // pfh_sec_model

// *** verification/testbench.sv ***
// self-checking bench for the primary fault handshake controller
`timescale 1ns/1ps
module testbench;
  import pfh_pkg::*;
  localparam int RON  = 4000;
  localparam int ROFF = 500;
  localparam int SIL  = 2000;
  localparam int LLOW = 100;
  localparam int JH   = 50;

  logic        clock;
  logic        rst;
  logic        supply_low, supply_regulated, supply_clear, big_cap_detect;
  logic        bypass_fault, latch_option, thermal_trip, thermal_cool;
  logic        thermal_latch_option, line_above_brown_in, line_below_brown_out;
  logic        line_over, line_pin_grounded, ac_reset, peak_fast, sw_off;
  logic        sec_request, p_en;
  logic [15:0] gap;
  logic        switch_enable, auto_pulse, limit_high, sense_switch_on;
  logic        latched_off, in_retry, sec_in_control;
  logic [6:0]  limit_pct;
  int          error_cnt  = 0;
  int          n_compared = 0;

  pfh_ctrl #(.RETRY_ON(RON), .RETRY_OFF(ROFF), .SILENCE(SIL), .LINE_LOW(LLOW),
    .JIT_HALF(JH)) DUT (.clock(clock), .rst(rst), .supply_low(supply_low),
    .supply_regulated(supply_regulated), .supply_clear(supply_clear),
    .big_cap_detect(big_cap_detect), .bypass_fault(bypass_fault),
    .latch_option(latch_option), .thermal_trip(thermal_trip),
    .thermal_cool(thermal_cool), .thermal_latch_option(thermal_latch_option),
    .line_above_brown_in(line_above_brown_in),
    .line_below_brown_out(line_below_brown_out), .line_over(line_over),
    .line_pin_grounded(line_pin_grounded), .ac_reset(ac_reset),
    .sec_request(sec_request), .peak_fast(peak_fast), .sw_off(sw_off),
    .switch_enable(switch_enable), .auto_pulse(auto_pulse),
    .limit_high(limit_high), .limit_pct(limit_pct),
    .sense_switch_on(sense_switch_on), .latched_off(latched_off),
    .in_retry(in_retry), .sec_in_control(sec_in_control));

  pfh_sec_model sec (.clock(clock), .rst(rst), .enable(p_en), .gap(gap),
    .sw_off(sw_off), .sec_request(sec_request), .rehandshake());

  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic chk1(string nm, logic exp, logic got);
    n_compared++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %s expected %b seen %b", nm, exp, got);
    end
  endtask

  task automatic chk7(string nm, logic [6:0] exp, logic [6:0] got);
    n_compared++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %s expected %0d seen %0d", nm, exp, got);
    end
  endtask

  function automatic logic pick(int k);
    case (k)
      0: return switch_enable;
      1: return latched_off;
      2: return in_retry;
      3: return sec_in_control;
      5: return auto_pulse;
      default: return limit_high;
    endcase
  endfunction

  task automatic cyc(int n);
    repeat (n) @(negedge clock);
  endtask

  // bounded wait, then judge what is there
  task automatic wait_val(int k, logic v, int lim, string nm);
    for (int i = 0; i < lim && pick(k) !== v; i++)
      @(negedge clock);
    chk1(nm, v, pick(k));
  endtask

  task automatic hold_val(int k, logic v, int n, string nm);
    int bad = 0;
    for (int i = 0; i < n; i++)
    begin
      @(negedge clock);
      if (pick(k) !== v)
        bad++;
    end
    chk1(nm, 1'b0, bad != 0);
  endtask

  task automatic power_up(logic big);
    rst = 1'b1;
    {supply_low, supply_clear, bypass_fault, latch_option, thermal_trip} = '0;
    {thermal_latch_option, line_below_brown_out, line_over} = '0;
    {line_pin_grounded, ac_reset, peak_fast, sw_off, p_en} = '0;
    {thermal_cool, supply_regulated, line_above_brown_in} = 3'b111;
    big_cap_detect = big;
    gap = 16'h03E8;
    cyc(3);
    rst = 1'b0;
  endtask

  task automatic to_sec;
    power_up(1'b0);
    p_en = 1'b1;
    wait_val(3, 1'b1, RON + 1200, "sec_in_control");
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_startup;
    power_up(1'b1);
    chk7("limit_pct", PCT_FULL, limit_pct);
    chk1("switch_enable", 1'b0, switch_enable);
    wait_val(4, 1'b1, 10, "limit_high");
    hold_val(0, 1'b0, 100, "switch_enable");
    hold_val(5, 1'b0, 50, "auto_pulse");
    wait_val(0, 1'b1, RON + 20, "switch_enable");
    chk1("sec_in_control", 1'b0, sec_in_control);
    wait_val(2, 1'b1, RON + 50, "in_retry");
    hold_val(0, 1'b0, ROFF - 10, "switch_enable");
  endtask

  task automatic t_handshake;
    power_up(1'b0);
    cyc(10);
    chk1("limit_high", 1'b0, limit_high);
    p_en = 1'b1;
    wait_val(3, 1'b1, RON + 1200, "sec_in_control");
    wait_val(0, 1'b1, 10, "switch_enable");
    p_en = 1'b0;
    wait_val(2, 1'b1, SIL + 50, "in_retry");
    ac_reset = 1'b1;
    wait_val(2, 1'b0, 6, "in_retry");
  endtask

  task automatic t_supply;
    to_sec();
    supply_low = 1'b1;
    supply_regulated = 1'b0;
    wait_val(0, 1'b0, 6, "switch_enable");
    supply_low = 1'b0;
    hold_val(0, 1'b0, 50, "switch_enable");
  endtask

  task automatic t_latch;
    to_sec();
    latch_option = 1'b1;
    bypass_fault = 1'b1;
    wait_val(1, 1'b1, 6, "latched_off");
    wait_val(0, 1'b0, 2, "switch_enable");
    chk1("in_retry", 1'b0, in_retry);
    bypass_fault = 1'b0;
    hold_val(1, 1'b1, 50, "latched_off");
    supply_clear = 1'b1;
    wait_val(1, 1'b0, 6, "latched_off");
    supply_clear = 1'b0;
    thermal_latch_option = 1'b1;
    thermal_trip = 1'b1;
    wait_val(1, 1'b1, 6, "latched_off");
    thermal_trip = 1'b0;
    line_above_brown_in = 1'b0;
    line_below_brown_out = 1'b1;
    wait_val(1, 1'b0, 6, "latched_off");
    {line_above_brown_in, line_below_brown_out} = 2'b10;
    latch_option = 1'b0;
    bypass_fault = 1'b1;
    wait_val(2, 1'b1, 6, "in_retry");
  endtask

  task automatic t_line;
    to_sec();
    line_pin_grounded = 1'b1;
    line_over = 1'b1;
    hold_val(2, 1'b0, 30, "in_retry");
    line_pin_grounded = 1'b0;
    wait_val(2, 1'b1, 6, "in_retry");
    to_sec();
    line_above_brown_in = 1'b0;
    line_below_brown_out = 1'b1;
    hold_val(2, 1'b0, LLOW / 2, "in_retry");
    wait_val(2, 1'b1, LLOW, "in_retry");
  endtask

  task automatic t_thermal;
    to_sec();
    thermal_cool = 1'b0;
    thermal_trip = 1'b1;
    wait_val(0, 1'b0, 6, "switch_enable");
    thermal_trip = 1'b0;
    hold_val(0, 1'b0, 50, "switch_enable");
    chk1("latched_off", 1'b0, latched_off);
    thermal_cool = 1'b1;
    wait_val(0, 1'b1, 6, "switch_enable");
  endtask

  task automatic t_overload;
    to_sec();
    gap = 16'h01F4;
    hold_val(2, 1'b0, RON / 2, "in_retry");
    wait_val(2, 1'b1, RON, "in_retry");
  endtask

  task automatic t_limit;
    logic [6:0] lo = PCT_FULL;
    logic [6:0] hi = PCT_FLOOR;
    int         n_on = 0;
    power_up(1'b0);
    sw_off = 1'b1;
    cyc(2);
    sw_off = 1'b0;
    cyc(9000);
    chk7("limit_pct", PCT_FLOOR, limit_pct);
    repeat (256)
    begin
      @(negedge clock);
      n_on += int'(sense_switch_on);
    end
    chk7("sense samples", 7'h01, 7'(n_on));
    for (int i = 0; i < 40; i++)
    begin
      sw_off = 1'b1;
      cyc(2);
      sw_off = 1'b0;
      cyc(18);
      chk1("sense_switch_on", 1'b1, sense_switch_on);
      if (limit_pct < lo)
        lo = limit_pct;
      if (limit_pct > hi)
        hi = limit_pct;
    end
    chk7("limit_pct max", PCT_FULL, hi);
    chk7("limit_pct min", PCT_JIT_LOW, lo);
  endtask

  task automatic final_report;
    if (error_cnt == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial
  begin
    #900000;
    error_cnt++;
    final_report();
  end

  initial
  begin
    t_startup();
    t_handshake();
    t_supply();
    t_latch();
    t_line();
    t_thermal();
    t_overload();
    t_limit();
    final_report();
  end
endmodule // testbench
